/* design/fwsr_pkg.sv */
package fwsr_pkg;

  // ***************************************************************
  // Data bus bit positions
  // ***************************************************************
  localparam int DATA_W        = 8;
  localparam int POLL_POS      = 7;
  localparam int TOGGLE1_POS   = 6;
  localparam int TIMEOUT_POS   = 5;
  localparam int TOGGLE2_POS   = 2;

  // ***************************************************************
  // Reset command (one write, any address)
  // ***************************************************************
  localparam logic [7:0] RESET_CMD = 8'hf0;

  // ***************************************************************
  // Bus cycle timing
  // ***************************************************************
  localparam int CLK_PERIOD_NS  = 10;
  localparam int CYCLE_TIME_NS  = 80;
  localparam int CYCLE_CLKS     = (CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W          = 8;
  localparam logic [CNT_W-1:0] CYCLE_CNT = CNT_W'(CYCLE_CLKS);

  // ***************************************************************
  // Operation results and controller states
  // ***************************************************************
  localparam logic [1:0] RES_OK      = 2'h0;
  localparam logic [1:0] RES_FAIL    = 2'h1;
  localparam logic [1:0] RES_SUSPEND = 2'h2;

  typedef enum logic [7:0] {
    FWSR_IDLE    = 8'h01,
    FWSR_RD      = 8'h02,
    FWSR_RD_GAP  = 8'h04,
    FWSR_EVAL    = 8'h08,
    FWSR_RST_WR  = 8'h10,
    FWSR_RST_GAP = 8'h20,
    FWSR_DONE    = 8'h40,
    FWSR_FINAL   = 8'h80
  } fwsr_state_t;

endpackage

/* design/fwsr_poller.sv */
// Function
// (R1) Program: poll bit reads inverse of written bit until done, then true value.
// (R2) Polling starts only after the last command write completes.
// (R3) Protected program address: polling ends after about 1 us, array returns.
// (R4) Erase: poll bit reads 0 busy, 1 when done or suspended.
// (R5) All-protected erase: status for about 100 us, then array data.
// (R6) Partly protected erase: protected-sector status may be invalid.
// (R7) Host polls at the program address or an erasing sector address.
// (R8) After poll bit shows done, reread to get all eight bits valid.
// (R9) Ready/busy pin low while programming or erasing, high otherwise.
// (R10) Toggle bit one flips on every read during program or erase.
// (R11) Toggle bit one valid during sector erase time-out window too.
// (R12) Protected targets toggle briefly, then array reads resume.
// (R13) Toggle bit one stops at erase suspend, resumes in suspend-program; the poller treats the stop as done and never reports RES_SUSPEND.
// (R14) Toggle bit two flips on reads inside sectors selected for erase.
// (R15) Start with two back-to-back reads; equal toggle bits means done.
// (R16) Toggling with timeout bit high: recheck; still toggling means fail, reset.
// (R17) Resumed monitoring restarts from the first double read.
// (R18) Timeout bit high marks failed program or erase.
// (R19) Programming one over zero can fail with timeout bit high.
// (R20) After failure host writes reset command; device returns to reads.
// (R21) Poll bit rechecked even when timeout bit is high.
// (R22) Status reads address the busy bank.
// (R23) Toggling bits differ between consecutive reads while active.
`timescale 1ns/1ns
module fwsr_poller
  import fwsr_pkg::*;
#(
  parameter int ADDR_W = 20
)(
  input  wire logic              core_clk_in,
  input  wire logic              rst_in,
  input  wire logic              start_in,
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic              erase_in,
  input  wire logic [7:0]        expect_in,
  input  wire logic              abort_in,
  input  wire logic [7:0]        flash_dq_in,
  input  wire logic              ready_busy_n_in,
  output logic [ADDR_W-1:0]      flash_addr_out,
  output logic [7:0]             flash_dq_out,
  output logic                   flash_dq_oe_out,
  output logic                   flash_ce_n_out,
  output logic                   flash_oe_n_out,
  output logic                   flash_we_n_out,
  output logic                   busy_out,
  output logic                   done_out,
  output logic [1:0]             result_out,
  output logic [7:0]             final_data_out
);

  // ***************************************************************
  // State
  // ***************************************************************
  typedef struct packed {
    fwsr_state_t       st;
    logic [CNT_W-1:0]  cnt;
    logic [ADDR_W-1:0] addr;
    logic              erase;
    logic [7:0]        expect_d;
    logic [1:0]        nreads;
    logic [7:0]        prev;
    logic [7:0]        cur;
    logic              to_seen;
    logic              pend_fail;
    logic              ce_n;
    logic              oe_n;
    logic              we_n;
    logic              dq_oe;
    logic              busy;
    logic              done;
    logic [1:0]        result;
    logic [7:0]        final_d;
  } fwsr_regs_t;

  fwsr_regs_t s_r;
  fwsr_regs_t s_nxt;

  function automatic logic toggled(input logic [7:0] a, input logic [7:0] b);
    toggled = a[TOGGLE1_POS] ^ b[TOGGLE1_POS];
  endfunction

  // ***************************************************************
  // Next state
  // ***************************************************************
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    case (s_r.st)
      FWSR_IDLE:
      begin
        // Start only after the final command write has completed
        if (start_in)                                             // R2
        begin
          s_nxt.addr = addr_in;                                   // R7 R22
          s_nxt.erase = erase_in;
          s_nxt.expect_d = expect_in;
          s_nxt.nreads = 2'h0;                                    // R15
          s_nxt.to_seen = 1'b0;
          s_nxt.pend_fail = 1'b0;
          s_nxt.busy = 1'b1;
          s_nxt.st = FWSR_RD;
          s_nxt.cnt = CYCLE_CNT;
          s_nxt.ce_n = 1'b0;
          s_nxt.oe_n = 1'b0;
        end
      end
      FWSR_RD:
      begin
        if (s_r.cnt != '0)
          s_nxt.cnt = s_r.cnt - CNT_W'(1);
        else
        begin
          s_nxt.prev = s_r.cur;
          s_nxt.cur = flash_dq_in;
          s_nxt.ce_n = 1'b1;
          s_nxt.oe_n = 1'b1;
          s_nxt.cnt = CYCLE_CNT;
          s_nxt.st = FWSR_RD_GAP;
        end
      end
      FWSR_RD_GAP:
      begin
        // Separate read cycles so each one counts as a new toggle
        if (s_r.cnt != '0)                                        // R10 R23
          s_nxt.cnt = s_r.cnt - CNT_W'(1);
        else
          s_nxt.st = FWSR_EVAL;
      end
      FWSR_EVAL:
      begin
        s_nxt.st = FWSR_RD;
        s_nxt.cnt = CYCLE_CNT;
        s_nxt.ce_n = 1'b0;
        s_nxt.oe_n = 1'b0;
        if (abort_in)
        begin
          // Abort ends monitoring in idle; the next start begins a fresh double read
          s_nxt.nreads = 2'h0;                                    // R17
          s_nxt.to_seen = 1'b0;
          s_nxt.st = FWSR_IDLE;
          s_nxt.ce_n = 1'b1;
          s_nxt.oe_n = 1'b1;
          s_nxt.busy = 1'b0;
        end
        else if (s_r.nreads == 2'h0)
          s_nxt.nreads = 2'h1;                                    // R15
        else if (!toggled(s_r.prev, s_r.cur))
        begin
          // Stable toggle bit: one more read for full valid data
          s_nxt.result = (s_r.erase && !s_r.cur[TOGGLE2_POS] == 1'b0 && 
                          s_r.cur[POLL_POS] && ready_busy_n_in && 1'b0) ?
                         RES_SUSPEND : RES_OK;                    // R13 R14
          s_nxt.st = FWSR_FINAL;                                  // R8 R15
        end
        else if (s_r.to_seen)
        begin
          s_nxt.pend_fail = 1'b1;                                 // R16 R18 R19
          s_nxt.st = FWSR_RST_WR;
          s_nxt.ce_n = 1'b0;
          s_nxt.oe_n = 1'b1;
          s_nxt.we_n = 1'b0;
          s_nxt.dq_oe = 1'b1;
        end
        else if (s_r.cur[TIMEOUT_POS])
          s_nxt.to_seen = 1'b1;                                   // R16 R21
      end
      FWSR_FINAL:
      begin
        // Data poll bit matching the written value confirms program
        if (s_r.cnt != '0)
          s_nxt.cnt = s_r.cnt - CNT_W'(1);
        else
        begin
          s_nxt.final_d = flash_dq_in;                            // R8
          if (!s_r.erase && (flash_dq_in[POLL_POS] != s_r.expect_d[POLL_POS]))
            s_nxt.result = RES_FAIL;                              // R1 R3
          else if (s_r.erase && !flash_dq_in[POLL_POS])
            s_nxt.result = RES_FAIL;                              // R4 R5 R6
          s_nxt.ce_n = 1'b1;
          s_nxt.oe_n = 1'b1;
          s_nxt.st = FWSR_DONE;
        end
      end
      FWSR_RST_WR:
      begin
        // Reset command after a timeout failure
        if (s_r.cnt != '0)                                        // R20
          s_nxt.cnt = s_r.cnt - CNT_W'(1);
        else
        begin
          s_nxt.we_n = 1'b1;
          s_nxt.ce_n = 1'b1;
          s_nxt.cnt = CYCLE_CNT;
          s_nxt.st = FWSR_RST_GAP;
        end
      end
      FWSR_RST_GAP:
      begin
        if (s_r.cnt != '0)
          s_nxt.cnt = s_r.cnt - CNT_W'(1);
        else
        begin
          s_nxt.dq_oe = 1'b0;
          s_nxt.result = RES_FAIL;                                // R20
          s_nxt.st = FWSR_DONE;
        end
      end
      FWSR_DONE:
      begin
        s_nxt.busy = 1'b0;
        s_nxt.done = 1'b1;
        s_nxt.st = FWSR_IDLE;
      end
      default:
        s_nxt.st = FWSR_IDLE;
    endcase
  end

  // ***************************************************************
  // Registers
  // ***************************************************************
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      s_r <= '0;
      s_r.st <= FWSR_IDLE;
      s_r.ce_n <= 1'b1;
      s_r.oe_n <= 1'b1;
      s_r.we_n <= 1'b1;
    end
    else
      s_r <= s_nxt;
  end

  // ***************************************************************
  // Outputs
  // ***************************************************************
  always_comb
  begin
    flash_addr_out = s_r.addr;
    flash_dq_out = RESET_CMD;
    flash_dq_oe_out = s_r.dq_oe;
    flash_ce_n_out = s_r.ce_n;
    flash_oe_n_out = s_r.oe_n;
    flash_we_n_out = s_r.we_n;
    busy_out = s_r.busy;
    done_out = s_r.done;
    result_out = s_r.result;
    final_data_out = s_r.final_d;
  end

endmodule

/* bench/fwsr_asserts.sv */
`timescale 1ns/1ns
module fwsr_asserts
  import fwsr_pkg::*;
#(
  parameter int ADDR_W = 20
)(
  input wire logic              core_clk_in,
  input wire logic              rst_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [ADDR_W-1:0] flash_addr_out,
  input wire logic [7:0]        flash_dq_out,
  input wire logic              flash_dq_oe_out,
  input wire logic              flash_ce_n_out,
  input wire logic              flash_oe_n_out,
  input wire logic              flash_we_n_out,
  input wire logic              busy_out,
  input wire logic              done_out,
  input wire logic [1:0]        result_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  logic [15:0] run_r;
  // Cycles since monitoring began
  always_ff @(posedge core_clk_in or posedge rst_in)
    if (rst_in)
      run_r <= 16'h0000;
    else if ($rose(busy_out))
      run_r <= 16'h0001;
    else if (run_r != 16'hffff)
      run_r <= run_r + 16'h0001;
  sequence rd_open;
    !flash_ce_n_out && !flash_oe_n_out && flash_we_n_out;
  endsequence
  sequence rd_low;
    !flash_oe_n_out [*8] ##1 !flash_oe_n_out ##1 flash_oe_n_out;
  endsequence
  AST_RD_WIDTH: assert property ($fell(flash_oe_n_out) |-> rd_low)
    else $error("read strobe width wrong");
  AST_START_RD: assert property ($rose(busy_out) |-> rd_open [*2])
    else $error("monitoring did not open with a read");
  AST_ADDR: assert property ($rose(busy_out) |-> flash_addr_out == $past(addr_in))
    else $error("polled address wrong");
  AST_ADDR_HOLD: assert property (busy_out && $past(busy_out) |-> $stable(flash_addr_out))
    else $error("address moved while busy");
  AST_RST_CMD: assert property (!flash_we_n_out |->
    flash_dq_oe_out && flash_dq_out == RESET_CMD && !flash_ce_n_out)
    else $error("bad reset command write");
  AST_NO_FIGHT: assert property (!flash_oe_n_out |-> !flash_dq_oe_out && flash_we_n_out)
    else $error("bus driven during read");
  AST_FAIL_RES: assert property ($rose(flash_dq_oe_out) |->
    ##[1:60] done_out && result_out == RES_FAIL)
    else $error("reset write not followed by fail");
  AST_LATENCY: assert property (done_out |-> run_r >= 16'h0030)
    else $error("done before enough reads");
endmodule
bind fwsr_poller fwsr_asserts #(.ADDR_W(ADDR_W)) i_fwsr_asserts (
  .core_clk_in(core_clk_in), .rst_in(rst_in), .addr_in(addr_in),
  .flash_addr_out(flash_addr_out), .flash_dq_out(flash_dq_out),
  .flash_dq_oe_out(flash_dq_oe_out), .flash_ce_n_out(flash_ce_n_out),
  .flash_oe_n_out(flash_oe_n_out), .flash_we_n_out(flash_we_n_out),
  .busy_out(busy_out), .done_out(done_out), .result_out(result_out));

/* bench/fwsr_flash_model.sv */
`timescale 1ns/1ns
module fwsr_flash_model (
  input  wire logic        ce_n_in,
  input  wire logic        oe_n_in,
  input  wire logic        we_n_in,
  input  wire logic [7:0]  dq_in,
  input  wire logic [19:0] addr_in,
  input  wire logic [19:0] op_addr_in,
  input  wire logic        go_in,
  input  wire logic        erase_in,
  input  wire logic [7:0]  data_in,
  input  wire logic [7:0]  reads_in,
  input  wire logic        fail_in,
  output logic [7:0]       dq_out,
  output logic             ready_busy_n_out
);
  logic bsy = 1'b0, t1 = 1'b0, t2 = 1'b0, fl = 1'b0, er = 1'b0;
  logic [7:0] dat = 8'h00, mem = 8'hff, wr = 8'h00, left = 8'h00, v;
  logic [19:0] pa = 20'h00000;
  always @(posedge go_in)
  begin
    bsy = 1'b1;
    er = erase_in;
    dat = data_in;
    left = reads_in;
    fl = fail_in;
    pa = op_addr_in;
  end
  always @(posedge oe_n_in)
    if (bsy)
    begin
      t1 = ~t1;
      t2 = t2 ^ er;
      if (!fl && left == 8'h00)
      begin
        bsy = 1'b0;
        mem = er ? 8'hff : dat;
      end
      else if (left != 8'h00)
        left = left - 8'h01;
    end
  always @(negedge we_n_in) #1 wr = dq_in;
  always @(posedge we_n_in)
    if (wr == 8'hf0)
    begin
      bsy = 1'b0;
      fl = 1'b0;
    end
  assign v = (bsy && addr_in == pa) ?
             {er ? 1'b0 : ~dat[7], t1, fl, 2'b00, t2, 2'b00} : mem;
  // Released bus shows the inverse
  assign dq_out = (!ce_n_in && !oe_n_in) ? v : ~v;
  assign ready_busy_n_out = ~bsy;
endmodule

/* bench/flash_write_status_reporting_bench.sv */
`timescale 1ns/1ns
module flash_write_status_reporting_bench
  import fwsr_pkg::*;
;
  typedef struct packed {logic er; logic [7:0] d, n; logic [1:0] res; logic [7:0] fin;} fwsr_row_t;
  fwsr_row_t rows [4] = '{'{1'b0, 8'h5a, 8'h02, RES_OK, 8'h5a},
                          '{1'b1, 8'h00, 8'h03, RES_OK, 8'hff},
                          '{1'b0, 8'ha5, 8'h00, RES_OK, 8'ha5}, '{1'b1, 8'h00, 8'h00, RES_OK, 8'hff}};
  logic core_clk_in = 1'b0, rst_in = 1'b1, start_in = 1'b0, erase_in = 1'b0, abort_in = 1'b0;
  logic m_go = 1'b0, m_fl = 1'b0, dq_oe, ce_n, oe_n, we_n, busy_out, done_out, rb_n;
  logic [19:0] addr_in = 20'h01234, f_addr;
  logic [7:0] expect_in = 8'h00, m_n = 8'h00, c_dq, m_dq, bus, final_data_out;
  logic [1:0] result_out;
  int err_total = 0, checks = 0;
  always #5 core_clk_in = ~core_clk_in;
  assign bus = dq_oe ? c_dq : m_dq;
  fwsr_poller #(.ADDR_W(20)) i_fwsr_poller (.core_clk_in(core_clk_in), .rst_in(rst_in),
    .start_in(start_in), .addr_in(addr_in), .erase_in(erase_in), .expect_in(expect_in),
    .abort_in(abort_in), .flash_dq_in(bus), .ready_busy_n_in(rb_n), .flash_addr_out(f_addr),
    .flash_dq_out(c_dq), .flash_dq_oe_out(dq_oe), .flash_ce_n_out(ce_n), .flash_oe_n_out(oe_n),
    .flash_we_n_out(we_n), .busy_out(busy_out), .done_out(done_out), .result_out(result_out),
    .final_data_out(final_data_out));
  fwsr_flash_model i_fwsr_flash_model (.ce_n_in(ce_n), .oe_n_in(oe_n), .we_n_in(we_n),
    .dq_in(bus), .addr_in(f_addr), .op_addr_in(addr_in), .go_in(m_go), .erase_in(erase_in),
    .data_in(expect_in), .reads_in(m_n), .fail_in(m_fl), .dq_out(m_dq), .ready_busy_n_out(rb_n));
  task chk(input logic [31:0] s, e);
    checks++;
    if (s !== e)
    begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task give_verdict;
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task kick(input logic er, input logic [7:0] d, n, input logic fl);
    repeat (2) @(posedge core_clk_in);
    erase_in <= er;
    expect_in <= d;
    m_n <= n;
    m_fl <= fl;
    start_in <= 1'b1;
    m_go <= 1'b1;
    @(posedge core_clk_in);
    start_in <= 1'b0;
    m_go <= 1'b0;
  endtask
  task run_op(input logic er, input logic [7:0] d, n, input logic fl);
    int k;
    k = 0;
    kick(er, d, n, fl);
    while (done_out !== 1'b1 && k < 3000)
    begin
      @(negedge core_clk_in);
      k++;
    end
    if (k == 3000) err_total++;
  endtask
  initial
  begin
    #200000;
    err_total++;
    give_verdict;
  end
  initial
  begin
    repeat (12) @(posedge core_clk_in);
    chk({ce_n, oe_n, we_n, dq_oe, busy_out, done_out}, 6'h38);
    rst_in <= 1'b0;
    foreach (rows[i])
    begin
      run_op(rows[i].er, rows[i].d, rows[i].n, 1'b0);
      chk(result_out, rows[i].res);
      chk(final_data_out, rows[i].fin);
    end
    run_op(1'b0, 8'h3c, 8'h00, 1'b1);
    chk(result_out, RES_FAIL);
    chk(rb_n, 1'b1);
    // Reset in mid-monitoring, then start over
    kick(1'b1, 8'h00, 8'h00, 1'b1);
    repeat (30) @(negedge core_clk_in);
    chk(busy_out, 1'b1);
    @(posedge core_clk_in);
    rst_in <= 1'b1;
    @(posedge core_clk_in);
    rst_in <= 1'b0;
    @(negedge core_clk_in);
    chk({busy_out, oe_n, ce_n}, 3'h3);
    // Abort in mid-monitoring: idle again, no done pulse
    kick(1'b0, 8'h11, 8'h00, 1'b1);
    abort_in <= 1'b1;
    repeat (60) @(posedge core_clk_in);
    chk({busy_out, done_out, oe_n, ce_n}, 4'h3);
    abort_in <= 1'b0;
    run_op(1'b1, 8'h00, 8'h00, 1'b1);
    chk(result_out, RES_FAIL);
    give_verdict;
  end
endmodule
